// *** core/standby_mode_control.sv ***
// Decided for this implementation: the register addresses and the AHB-Lite interface to the registers.
module standby_mode_control (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HSEL,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [standby_pkg::NUM_IRQ*4-1:0] IRQ_SRC,
  output logic CPU_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic OSC_EN,
  output logic PIN_HIZ,
  output logic SOFT_RESET,
  output logic WAKE_BRANCH,
  output logic WAKE_RESUME
);

  // ****************************************************************
  // Pin-side interrupt inputs, three-stage synchronisers
  // ****************************************************************
  logic [standby_pkg::NUM_IRQ*4-1:0] irq_s1_r;
  logic [standby_pkg::NUM_IRQ*4-1:0] irq_s2_r;
  logic [standby_pkg::NUM_IRQ*4-1:0] irq_s3_r;
  logic [standby_pkg::NUM_IRQ*4-1:0] irq_q_r;
  logic [standby_pkg::NUM_IRQ*4-1:0] irq_q_nxt;

  // A change only counts once stages two and three agree
  always_comb
  begin
    irq_q_nxt = irq_q_r;
    for (int i = 0; i < standby_pkg::NUM_IRQ * 4; i++)
    begin
      if (irq_s2_r[i] == irq_s3_r[i])
      begin
        irq_q_nxt[i] = irq_s3_r[i];
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      irq_s1_r <= '0;
      irq_s2_r <= '0;
      irq_s3_r <= '0;
      irq_q_r <= '0;
    end
    else
    begin
      irq_s1_r <= IRQ_SRC;
      irq_s2_r <= irq_s1_r;
      irq_s3_r <= irq_s2_r;
      irq_q_r <= irq_q_nxt;
    end
  end

  // ****************************************************************
  // Per-source qualification
  // ****************************************************************
  standby_pkg::irq_src_type src [standby_pkg::NUM_IRQ];
  logic [standby_pkg::NUM_IRQ-1:0] any_q;
  logic [standby_pkg::NUM_IRQ-1:0] ext_q;
  logic [standby_pkg::NUM_IRQ-1:0] acc_q;
  logic [1:0] cpu_prio_r;
  logic [1:0] cpu_prio_nxt;
  logic gie_r;
  logic gie_nxt;

  // Levels are interrupt-level codes: smaller code means stronger
  genvar g;
  generate
    for (g = 0; g < standby_pkg::NUM_IRQ; g++)
    begin : g_src
      assign src[g] = standby_pkg::irq_src_type'(irq_q_r[g*4 +: 4]);
      assign any_q[g] = src[g].pend && (src[g].level < standby_pkg::WAKE_LEVEL_THRESH);
      assign ext_q[g] = any_q[g] && src[g].ext;
      assign acc_q[g] = any_q[g] && (src[g].level < cpu_prio_r);
    end
  endgenerate

  logic irq_block;
  logic wake_sleep;
  logic wake_stop;
  logic accept;
  assign irq_block = |any_q;
  assign wake_sleep = |any_q;
  assign wake_stop = |ext_q; // only external sources run in stop
  assign accept = (|acc_q) && gie_r;

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  logic wr_pend_r;
  logic wr_pend_nxt;
  logic [7:0] wr_addr_r;
  logic [7:0] wr_addr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic pin_hiz_cfg_r;
  logic pin_hiz_cfg_nxt;
  logic osc_sel_r;
  logic osc_sel_nxt;
  logic take;
  standby_pkg::pwr_state_type st_r;
  standby_pkg::pwr_state_type st_nxt;

  assign take = HSEL && HREADY && HTRANS[1];

  // Read data captured in address phase: zero wait states
  always_comb
  begin
    wr_pend_nxt = take && HWRITE;
    wr_addr_nxt = take ? HADDR[7:0] : wr_addr_r;
    rdata_nxt = rdata_r;
    if (take && !HWRITE)
    begin
      rdata_nxt = 32'h0000_0000;
      case (HADDR[7:0])
        standby_pkg::STBY_CTRL_OFS:
        begin
          // Request bits always read zero, reset bit reads one
          rdata_nxt[standby_pkg::PIN_HIZ_POS] = pin_hiz_cfg_r;
          rdata_nxt[standby_pkg::SWRST_POS] = 1'b1;
          rdata_nxt[standby_pkg::OSC_SEL_POS] = osc_sel_r;
        end
        standby_pkg::STBY_STAT_OFS:
        begin
          rdata_nxt[2:0] = st_r;
          rdata_nxt[3] = irq_block;
        end
        standby_pkg::CPU_PRIO_OFS:
        begin
          rdata_nxt[1:0] = cpu_prio_r;
          rdata_nxt[standby_pkg::GIE_POS] = gie_r;
        end
        default:
        begin
          rdata_nxt = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign HRDATA = rdata_r;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // ****************************************************************
  // Control writes and mode request decode
  // ****************************************************************
  logic ctrl_wr;
  logic stop_req;
  logic sleep_req;
  logic [2:0] rst_cnt_r;
  logic [2:0] rst_cnt_nxt;
  standby_pkg::sel_mode_type req_mode;

  assign ctrl_wr = wr_pend_r && (wr_addr_r == standby_pkg::STBY_CTRL_OFS);
  assign stop_req = ctrl_wr && HWDATA[standby_pkg::STOP_BIT_POS];
  assign sleep_req = ctrl_wr && HWDATA[standby_pkg::SLEEP_BIT_POS];

  // Stop outranks sleep when both are written
  always_comb
  begin
    if (stop_req)
    begin
      req_mode = standby_pkg::STOP_MODE;
    end
    else if (sleep_req)
    begin
      req_mode = standby_pkg::SLEEP_MODE;
    end
    else
    begin
      req_mode = standby_pkg::RUN_MODE; // no request bit set: no mode change
    end
  end

  // Config fields and software reset pulse
  always_comb
  begin
    pin_hiz_cfg_nxt = pin_hiz_cfg_r;
    osc_sel_nxt = osc_sel_r;
    cpu_prio_nxt = cpu_prio_r;
    gie_nxt = gie_r;
    rst_cnt_nxt = (rst_cnt_r != 3'h0) ? rst_cnt_r - 3'h1 : 3'h0;
    if (ctrl_wr)
    begin
      pin_hiz_cfg_nxt = HWDATA[standby_pkg::PIN_HIZ_POS];
      osc_sel_nxt = HWDATA[standby_pkg::OSC_SEL_POS];
      if (!HWDATA[standby_pkg::SWRST_POS])
      begin
        rst_cnt_nxt = 3'(standby_pkg::SWRST_CYC);
      end
    end
    if (wr_pend_r && (wr_addr_r == standby_pkg::CPU_PRIO_OFS))
    begin
      cpu_prio_nxt = HWDATA[1:0];
      gie_nxt = HWDATA[standby_pkg::GIE_POS];
    end
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      pin_hiz_cfg_r <= standby_pkg::PIN_HIZ_RST;
      osc_sel_r <= standby_pkg::OSC_SEL_RST;
      cpu_prio_r <= standby_pkg::CPU_PRIO_RST;
      gie_r <= 1'b0;
      rst_cnt_r <= 3'h0;
    end
    else
    begin
      pin_hiz_cfg_r <= pin_hiz_cfg_nxt;
      osc_sel_r <= osc_sel_nxt;
      cpu_prio_r <= cpu_prio_nxt;
      gie_r <= gie_nxt;
      rst_cnt_r <= rst_cnt_nxt;
    end
  end

  // ****************************************************************
  // Power state machine
  // ****************************************************************
  logic osc_start;
  logic osc_done;
  logic branch_nxt;
  logic resume_nxt;
  logic branch_r;
  logic resume_r;

  osc_wait_timer u_osc_wait (
    .clk(REF_CLK),
    .rst(SYS_RST),
    .start(osc_start),
    .long_sel(osc_sel_r),
    .done(osc_done)
  );

  // Blocked request is dropped, never retried later
  always_comb
  begin
    st_nxt = st_r;
    osc_start = 1'b0;
    branch_nxt = 1'b0;
    resume_nxt = 1'b0;
    case (st_r)
      standby_pkg::ST_RUN:
      begin
        if (!irq_block)
        begin
          if (req_mode == standby_pkg::STOP_MODE)
          begin
            st_nxt = standby_pkg::ST_STOP;
          end
          else if (req_mode == standby_pkg::SLEEP_MODE)
          begin
            st_nxt = standby_pkg::ST_SLEEP;
          end
        end
      end
      standby_pkg::ST_SLEEP:
      begin
        if (wake_sleep)
        begin
          st_nxt = standby_pkg::ST_WAKE; // no delay
        end
      end
      standby_pkg::ST_STOP:
      begin
        if (wake_stop)
        begin
          st_nxt = standby_pkg::ST_OSC_WAIT;
          osc_start = 1'b1;
        end
      end
      standby_pkg::ST_OSC_WAIT:
      begin
        if (osc_done)
        begin
          st_nxt = standby_pkg::ST_WAKE;
        end
      end
      standby_pkg::ST_WAKE:
      begin
        // Acceptance judged after the clock is back
        branch_nxt = accept;
        resume_nxt = !accept;
        st_nxt = standby_pkg::ST_RUN;
      end
      default:
      begin
        st_nxt = standby_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_r <= standby_pkg::ST_RUN;
      branch_r <= 1'b0;
      resume_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      branch_r <= branch_nxt;
      resume_r <= resume_nxt;
    end
  end

  // ****************************************************************
  // Clock, pin and reset outputs
  // ****************************************************************
  logic cpu_en_r;
  logic per_en_r;
  logic osc_en_r;
  logic hiz_r;
  logic srst_r;

  // Registered so every control output comes from a flop
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      cpu_en_r <= 1'b1;
      per_en_r <= 1'b1;
      osc_en_r <= 1'b1;
      hiz_r <= 1'b0;
      srst_r <= 1'b0;
    end
    else
    begin
      cpu_en_r <= (st_nxt == standby_pkg::ST_RUN) || (st_nxt == standby_pkg::ST_WAKE);
      per_en_r <= (st_nxt != standby_pkg::ST_STOP) && (st_nxt != standby_pkg::ST_OSC_WAIT);
      osc_en_r <= (st_nxt != standby_pkg::ST_STOP);
      hiz_r <= (st_nxt == standby_pkg::ST_STOP) && pin_hiz_cfg_r;
      srst_r <= (rst_cnt_nxt != 3'h0);
    end
  end

  assign CPU_CLK_EN = cpu_en_r;
  assign PERIPH_CLK_EN = per_en_r;
  assign OSC_EN = osc_en_r;
  assign PIN_HIZ = hiz_r;
  assign SOFT_RESET = srst_r;
  assign WAKE_BRANCH = branch_r;
  assign WAKE_RESUME = resume_r;

endmodule // standby_mode_control

// *** core/standby_pkg.sv ***
package standby_pkg;

  // ****************************************************************
  // Register map (byte addresses, one word each)
  // ****************************************************************
  localparam logic [7:0] STBY_CTRL_OFS = 8'h00;
  localparam logic [7:0] STBY_STAT_OFS = 8'h04;
  localparam logic [7:0] CPU_PRIO_OFS = 8'h08;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int STOP_BIT_POS = 7;
  localparam int SLEEP_BIT_POS = 6;
  localparam int PIN_HIZ_POS = 5;
  localparam int SWRST_POS = 4;
  localparam int OSC_SEL_POS = 0;
  localparam int GIE_POS = 2;
  localparam logic [1:0] WAKE_LEVEL_THRESH = 2'h3;
  localparam logic [1:0] CPU_PRIO_RST = 2'h3;
  localparam logic PIN_HIZ_RST = 1'b0;
  localparam logic OSC_SEL_RST = 1'b0;
  localparam int NUM_IRQ = 8;

  // ****************************************************************
  // Timing: stabilization delays in us, counted in REF_CLK cycles
  // ****************************************************************
  localparam int CLK_MHZ = 200;
  localparam int OSC_SHORT_US = 4;
  localparam int OSC_LONG_US = 16;
  localparam int OSC_SHORT_CYC = OSC_SHORT_US * CLK_MHZ;
  localparam int OSC_LONG_CYC = OSC_LONG_US * CLK_MHZ;
  localparam int SWRST_CYC = 4;

  typedef enum logic [1:0] {
    RUN_MODE,
    SLEEP_MODE,
    STOP_MODE
  } sel_mode_type;

  // One interrupt source: pending flag, level, external origin
  typedef struct packed {
    logic pend;
    logic ext;
    logic [1:0] level;
  } irq_src_type;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_SLEEP,
    ST_STOP,
    ST_OSC_WAIT,
    ST_WAKE
  } pwr_state_type;

endpackage : standby_pkg

// *** core/osc_wait_timer.sv ***
module osc_wait_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic long_sel,
  output logic done
);

  // ****************************************************************
  // Stabilization countdown
  // ****************************************************************
  logic [13:0] cnt_r;
  logic [13:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;

  // Load on start, count down, pulse done at zero
  always_comb
  begin
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done = 1'b0;
    if (start)
    begin
      cnt_nxt = long_sel ? 14'(standby_pkg::OSC_LONG_CYC - 1)
                         : 14'(standby_pkg::OSC_SHORT_CYC - 1);
      busy_nxt = 1'b1;
    end
    else if (busy_r)
    begin
      if (cnt_r == 14'h0000)
      begin
        busy_nxt = 1'b0;
        done = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r - 14'h0001;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 14'h0000;
      busy_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

endmodule // osc_wait_timer

// *** tb/standby_props.sv ***
module standby_props (
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HSEL,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic [standby_pkg::NUM_IRQ*4-1:0] IRQ_SRC,
  input wire logic CPU_CLK_EN,
  input wire logic PERIPH_CLK_EN,
  input wire logic OSC_EN,
  input wire logic WAKE_BRANCH,
  input wire logic WAKE_RESUME
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Helpers: irq ages and ctrl write data phase
  // ****************************************************************
  logic qual;
  logic [2:0] q_cnt_r, q_cnt_nxt, nq_cnt_r, nq_cnt_nxt;
  logic wr_r, wr_nxt;
  // Ages saturate at 7; six cycles covers the input synchronizer
  always_comb
  begin
    qual = 1'b0;
    for (int i = 0; i < standby_pkg::NUM_IRQ; i++)
    begin
      qual = qual | (IRQ_SRC[4*i+3] & (IRQ_SRC[4*i+1 -: 2] != 2'h3));
    end
    q_cnt_nxt = !qual ? 3'h0 : (q_cnt_r == 3'h7) ? q_cnt_r : q_cnt_r + 3'h1;
    nq_cnt_nxt = qual ? 3'h0 : (nq_cnt_r == 3'h7) ? nq_cnt_r : nq_cnt_r + 3'h1;
    wr_nxt = HSEL & HREADY & HTRANS[1] & HWRITE & (HADDR[7:0] == standby_pkg::STBY_CTRL_OFS);
  end
  // Registers only
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      q_cnt_r <= 3'h0;
      nq_cnt_r <= 3'h0;
      wr_r <= 1'b0;
    end
    else
    begin
      q_cnt_r <= q_cnt_nxt;
      nq_cnt_r <= nq_cnt_nxt;
      wr_r <= wr_nxt;
    end
  end

  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  block_req_a: assert property (wr_r && HREADYOUT && HWDATA[7:6] != 2'b00 && q_cnt_r >= 3'h6 && CPU_CLK_EN |-> CPU_CLK_EN[*4])
    else $error("standby entered with irq pending");
  enter_stop_a: assert property (wr_r && HREADYOUT && HWDATA[7] && nq_cnt_r >= 3'h6 && CPU_CLK_EN |-> ##[1:4] !OSC_EN)
    else $error("stop not entered");
  enter_sleep_a: assert property (wr_r && HREADYOUT && HWDATA[7:6] == 2'b01 && nq_cnt_r >= 3'h6 && CPU_CLK_EN |-> ##[1:4] (!CPU_CLK_EN && OSC_EN))
    else $error("sleep not entered");
  sleep_wake_a: assert property (!CPU_CLK_EN && PERIPH_CLK_EN && q_cnt_r >= 3'h3 |-> ##[0:4] CPU_CLK_EN)
    else $error("no wake from sleep");
  osc_wait_a: assert property ($rose(OSC_EN) |-> !CPU_CLK_EN[*8])
    else $error("cpu clock before stabilization");
  stop_halt_a: assert property (!OSC_EN |-> !CPU_CLK_EN && !PERIPH_CLK_EN)
    else $error("clocks running with oscillator off");
  wake_pulse_a: assert property ($rose(CPU_CLK_EN) |-> ##[0:3] (WAKE_BRANCH || WAKE_RESUME))
    else $error("wake without branch or resume");
  wake_excl_a: assert property (!(WAKE_BRANCH && WAKE_RESUME))
    else $error("branch and resume together");
  req_read_a: assert property ($past(HSEL && HREADY && HTRANS[1] && !HWRITE && HADDR[7:0] == 8'h00) |-> HRDATA[7:6] == 2'b00)
    else $error("request bits read nonzero");
endmodule // standby_props

bind standby_mode_control standby_props standby_props_i (.REF_CLK, .SYS_RST, .HADDR, .HTRANS,
  .HWRITE, .HSEL, .HREADY, .HWDATA, .HRDATA, .HREADYOUT, .IRQ_SRC, .CPU_CLK_EN,
  .PERIPH_CLK_EN, .OSC_EN, .WAKE_BRANCH, .WAKE_RESUME);

// *** tb/irq_partner.sv ***
module irq_partner #(
  parameter int TICK_CYC = 40
) (
  input wire logic clk,
  input wire logic run_en,
  input wire logic tick_en,
  output logic [standby_pkg::NUM_IRQ*4-1:0] irq_src
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Interrupt sources and timebase
  // ****************************************************************
  standby_pkg::irq_src_type src [standby_pkg::NUM_IRQ];
  int tick_cnt = 0;
  // Pending stays until software clears it
  task automatic raise(input int i, input logic [1:0] lvl, input logic ext);
    src[i] <= '{pend: 1'b1, ext: ext, level: lvl};
  endtask
  task automatic clear(input int i);
    src[i] <= '0;
  endtask
  initial
  begin
    foreach (src[i]) src[i] = '0;
  end
  // Timebase interval fires whenever enabled; it halts with the peripheral clock
  always @(posedge clk)
  begin
    if (tick_en && run_en)
    begin
      tick_cnt <= (tick_cnt == TICK_CYC - 1) ? 0 : tick_cnt + 1;
      if (tick_cnt == TICK_CYC - 1) src[7] <= '{pend: 1'b1, ext: 1'b0, level: 2'h2};
    end
  end
  // Pack sources onto the wire
  always_comb
  begin
    for (int i = 0; i < standby_pkg::NUM_IRQ; i++) irq_src[4*i +: 4] = src[i];
  end
endmodule // irq_partner

// *** tb/tb.sv ***
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Bench signals
  // ****************************************************************
  logic ref_clk = 1'b0, sys_rst = 1'b1, hwrite = 1'b0, hsel = 1'b0, tick_en = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, irq_src, q;
  logic hreadyout, hresp, cpu_clk_en, periph_clk_en, osc_en, pin_hiz, soft_reset;
  logic wake_branch, wake_resume, br;
  int failures = 0, n_tests = 0, cyc, lvl, pr, gie, osc;
  standby_mode_control standby_mode_control_i (.REF_CLK(ref_clk), .SYS_RST(sys_rst),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HSEL(hsel),
    .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .IRQ_SRC(irq_src), .CPU_CLK_EN(cpu_clk_en), .PERIPH_CLK_EN(periph_clk_en),
    .OSC_EN(osc_en), .PIN_HIZ(pin_hiz), .SOFT_RESET(soft_reset),
    .WAKE_BRANCH(wake_branch), .WAKE_RESUME(wake_resume));
  irq_partner irq_partner_i (.clk(ref_clk), .run_en(periph_clk_en), .tick_en(tick_en),
    .irq_src(irq_src));
  // 200 MHz clock
  initial
  begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      failures++;
    end
  endtask
  task automatic close_out();
    if (failures == 0 && n_tests > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Bounded wait for ready; the slave may stretch in principle
  task automatic wait_rdy();
    int k;
    k = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1)
    begin
      k++;
      if (k > 50) failures++;
      if (k > 50) close_out();
      @(posedge ref_clk);
    end
  endtask
  // One single AHB transfer; read data taken at the data phase's end
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    haddr <= {24'h0, a};
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    q = hrdata;
  endtask
  // Wait for the wake pulse; also counts cycles for the stabilization check
  task automatic wait_wake();
    cyc = 0;
    while (wake_branch !== 1'b1 && wake_resume !== 1'b1)
    begin
      @(posedge ref_clk);
      cyc++;
      if (cyc > 4000) failures++;
      if (cyc > 4000) close_out();
    end
    br = wake_branch;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    void'($urandom(32'hd975));
    repeat (8) @(posedge ref_clk);
    sys_rst <= 1'b0;
    bus(0, standby_pkg::STBY_CTRL_OFS, 0);
    chk("ctrl_bits", q & 32'he0, 32'h0);
    bus(0, standby_pkg::CPU_PRIO_OFS, 0);
    chk("prio_rst", q & 32'h7, 32'h3);
    bus(0, 8'h10, 0);
    chk("unmapped", q, 32'h0);
    chk("resp_okay", hresp, 32'h0);
    bus(1, standby_pkg::STBY_CTRL_OFS, 32'h10);
    bus(0, standby_pkg::STBY_STAT_OFS, 0);
    chk("zero_write", q & 32'h7, 32'h0);
    // Writing zero to the reset bit pulses the soft reset for a fixed count
    bus(1, standby_pkg::STBY_CTRL_OFS, 32'h0);
    repeat (standby_pkg::SWRST_CYC) @(posedge ref_clk);
    chk("srst_len", soft_reset, 32'h1);
    @(posedge ref_clk);
    chk("srst_end", soft_reset, 32'h0);
    // Timebase wakes sleep; priority 0 refuses it
    bus(1, standby_pkg::CPU_PRIO_OFS, 32'h0);
    bus(1, standby_pkg::STBY_CTRL_OFS, 32'h50);
    bus(0, standby_pkg::STBY_STAT_OFS, 0);
    chk("sleep_state", q & 32'h7, 32'h1);
    chk("sleep_clks", {cpu_clk_en, periph_clk_en, osc_en}, 32'h3);
    tick_en <= 1'b1;
    wait_wake();
    chk("tb_resume", br, 32'h0);
    tick_en <= 1'b0;
    irq_partner_i.clear(7);
    // Random level, priority and enable against the acceptance model
    repeat (4)
    begin
      lvl = $urandom_range(2, 0);
      pr = $urandom_range(3, 0);
      gie = $urandom_range(1, 0);
      bus(1, standby_pkg::CPU_PRIO_OFS, gie * 4 + pr);
      bus(1, standby_pkg::STBY_CTRL_OFS, 32'h50);
      bus(0, standby_pkg::STBY_STAT_OFS, 0);
      chk("sleep_loop", q & 32'h7, 32'h1);
      irq_partner_i.raise(1, lvl, 1'b0);
      wait_wake();
      chk("accept", br, (gie == 1 && lvl < pr));
      irq_partner_i.clear(1);
      repeat (8) @(posedge ref_clk);
    end
    // Stop via both bits, both stabilization choices
    for (int s = 0; s < 2; s++)
    begin
      osc = s ? standby_pkg::OSC_LONG_CYC : standby_pkg::OSC_SHORT_CYC;
      bus(1, standby_pkg::CPU_PRIO_OFS, 32'h7);
      bus(1, standby_pkg::STBY_CTRL_OFS, 32'hf0 | s);
      bus(0, standby_pkg::STBY_STAT_OFS, 0);
      chk("stop_prio", q & 32'h7, 32'h2);
      chk("stop_pins", {pin_hiz, osc_en}, 32'h2);
      irq_partner_i.raise(2, 2'h0, 1'b0);
      repeat (20) @(posedge ref_clk);
      bus(0, standby_pkg::STBY_STAT_OFS, 0);
      chk("stop_hold", q & 32'h7, 32'h2);
      irq_partner_i.clear(2);
      irq_partner_i.raise(0, 2'h1, 1'b1);
      wait_wake();
      chk("osc_wait", (cyc >= osc && cyc <= osc + 16), 32'h1);
      chk("stop_branch", br, 32'h1);
      chk("hiz_wake", pin_hiz, 32'h0);
      irq_partner_i.clear(0);
      repeat (8) @(posedge ref_clk);
    end
    // Pending irq blocks a request for good; a disabled level does not
    bus(1, standby_pkg::CPU_PRIO_OFS, 32'h0);
    irq_partner_i.raise(3, 2'h0, 1'b0);
    irq_partner_i.raise(4, 2'h3, 1'b0);
    repeat (8) @(posedge ref_clk);
    bus(1, standby_pkg::STBY_CTRL_OFS, 32'h90);
    bus(0, standby_pkg::STBY_STAT_OFS, 0);
    chk("blocked", q & 32'h7, 32'h0);
    irq_partner_i.clear(3);
    repeat (8) @(posedge ref_clk);
    bus(0, standby_pkg::STBY_STAT_OFS, 0);
    chk("dropped", q & 32'h7, 32'h0);
    bus(1, standby_pkg::STBY_CTRL_OFS, 32'h50);
    bus(0, standby_pkg::STBY_STAT_OFS, 0);
    chk("after_clear", q & 32'h7, 32'h1);
    irq_partner_i.raise(3, 2'h2, 1'b1);
    wait_wake();
    chk("last_resume", br, 32'h0);
    close_out();
  end
endmodule // tb
